// ==== common/xmb_pkg.sv ====
// Package for the external memory and I/O bus master.
package xmb_pkg;

  // ----------------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  typedef enum logic [1:0] {
    XMB_SP_DATA,
    XMB_SP_PROG,
    XMB_SP_IO
  } xmb_space_t;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // Not used by the bus master, whose strobe stays low for at least three cycles in one bus cycle.
  localparam int          MIN_CYC  = 1;
  // Ready passes two flops, so the first sample that belongs to the cycle
  // is three edges after the strobe falls.
  localparam logic [1:0]  FIRST_WAIT = 2'h2;
  // A later sample only needs one wait to see a fresh ready value.
  localparam logic [1:0]  RDY_WAIT   = 2'h1;

  typedef struct packed {
    logic              write;
    xmb_space_t        space;
    logic [15:0]       addr;
    logic [15:0]       wdata;
  } xmb_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        ds_n;
    logic        ps_n;
    logic        is_n;
    logic        rw;
    logic        wr;
    logic        bus_cycle_n_n;
    logic        we_n;
  } xmb_pins_t;

endpackage : xmb_pkg

// ==== hw/xmb_sync.sv ====
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module xmb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_r;
  logic [W-1:0] s2_nxt;

  // Only the second flop is read outside, so a metastable first stage
  // has a whole cycle to settle.
  always_comb begin
    s1_nxt = d_i;
    s2_nxt = s1_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q_o = s2_r;

endmodule : xmb_sync

// ==== hw/xmb_bus.sv ====
// Bus master for the external memory and I/O bus.
`timescale 1ns/1ps
module xmb_bus (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  // Mode pins
  input  wire logic                 emu_off_n_i,
  input  wire logic                 power_down_i,
  // Core request
  input  wire logic                 req_valid_i,
  input  wire xmb_pkg::xmb_req_t    req_i,
  output logic                      req_ready_o,
  output logic                      rsp_valid_o,
  output logic [15:0]               rsp_rdata_o,
  // External bus
  input  wire logic                 ready_i,
  output xmb_pkg::xmb_pins_t        pins_o,
  output logic                      ctl_oe_o,
  output logic                      addr_oe_o,
  input  wire logic [15:0]          ext_data_i,
  output logic [15:0]               ext_data_o,
  output logic                      ext_data_oe_o
);

  default clocking cb_chk @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0]  pin_s;
  logic [15:0] data_s;
  logic        rdy_s;
  logic        off_n_s;

  xmb_sync #(
    .W (2)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({ready_i, emu_off_n_i}),
    .q_o       (pin_s)
  );

  // Data goes through the same depth as ready, so both show one instant.
  xmb_sync #(
    .W (16)
  ) u_data_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (ext_data_i),
    .q_o       (data_s)
  );

  assign rdy_s   = pin_s[1];
  assign off_n_s = pin_s[0];

  // ----------------------------------------------------------------------
  // Bus cycle state machine
  // ----------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_CYC, ST_END} xmb_st_t;

  xmb_st_t            st_r;
  xmb_st_t            st_nxt;
  xmb_pkg::xmb_req_t  cur_r;
  xmb_pkg::xmb_req_t  cur_nxt;
  logic [15:0]        addr_r;
  logic [15:0]        addr_nxt;
  logic               rv_r;
  logic               rv_nxt;
  logic [15:0]        rd_r;
  logic [15:0]        rd_nxt;
  logic [1:0]         wait_r;
  logic [1:0]         wait_nxt;

  logic active;
  assign active = off_n_s && !power_down_i && !rst_i;

  // Ready reaches this logic two edges late, so the first sample waits
  // until it reflects a time when the strobe was already low.
  always_comb begin
    st_nxt   = st_r;
    cur_nxt  = cur_r;
    addr_nxt = addr_r;
    rv_nxt   = 1'b0;
    rd_nxt   = rd_r;
    wait_nxt = wait_r;
    case (st_r)
      ST_IDLE: begin
        if (req_valid_i && active) begin
          cur_nxt  = req_i;
          addr_nxt = req_i.addr;
          wait_nxt = xmb_pkg::FIRST_WAIT;
          st_nxt   = ST_CYC;
        end
      end
      ST_CYC: begin
        if (wait_r != 2'h0) begin
          wait_nxt = wait_r - 2'h1;
        end else if (rdy_s) begin
          rd_nxt = data_s;
          st_nxt = ST_END;
        end else begin
          wait_nxt = xmb_pkg::RDY_WAIT;
        end
      end
      ST_END: begin
        rv_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r   <= ST_IDLE;
      cur_r  <= '0;
      addr_r <= xmb_pkg::ADDR_RST;
      rv_r   <= 1'b0;
      rd_r   <= xmb_pkg::DATA_RST;
      wait_r <= 2'h0;
    end else begin
      st_r   <= st_nxt;
      cur_r  <= cur_nxt;
      addr_r <= addr_nxt;
      rv_r   <= rv_nxt;
      rd_r   <= rd_nxt;
      wait_r <= wait_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------
  logic in_cyc;
  logic wr_cyc;
  assign in_cyc = (st_r == ST_CYC);
  assign wr_cyc = in_cyc && cur_r.write;

  assign req_ready_o = (st_r == ST_IDLE) && active;
  assign rsp_valid_o = rv_r;
  assign rsp_rdata_o = rd_r;

  always_comb begin
    pins_o.addr   = addr_r;
    pins_o.ds_n   = !(in_cyc && cur_r.space == xmb_pkg::XMB_SP_DATA);
    pins_o.ps_n   = !(in_cyc && cur_r.space == xmb_pkg::XMB_SP_PROG);
    pins_o.is_n   = !(in_cyc && cur_r.space == xmb_pkg::XMB_SP_IO);
    pins_o.rw     = !wr_cyc;
    pins_o.wr     = wr_cyc;
    pins_o.bus_cycle_n_n = !in_cyc;
    // Rises with the strobe, at the edge where the data is released.
    pins_o.we_n   = !wr_cyc;
  end

  assign addr_oe_o     = off_n_s;
  assign ctl_oe_o      = active;
  assign ext_data_o    = cur_r.wdata;
  assign ext_data_oe_o = wr_cyc && active;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_one_select: assert property (
    $onehot0({!pins_o.ds_n, !pins_o.ps_n, !pins_o.is_n}))
    else $error("more than one space select low");
  a_addr_stable: assert property (
    (!pins_o.bus_cycle_n_n && $past(!pins_o.bus_cycle_n_n)) |-> $stable(pins_o.addr))
    else $error("address moved during strobe");
  a_wr_inverse: assert property (
    pins_o.wr == !pins_o.rw)
    else $error("write line not inverse of direction");
  a_data_drive: assert property (
    ext_data_oe_o |-> (!pins_o.we_n && !pins_o.rw))
    else $error("data driven outside write");
  a_we_write: assert property (
    !pins_o.we_n |-> (!pins_o.bus_cycle_n_n && !pins_o.rw))
    else $error("write enable outside write cycle");
  a_ready_wait: assert property (
    (in_cyc && wait_r == 2'h0 && !rdy_s) |=>
      (in_cyc && wait_r == xmb_pkg::RDY_WAIT))
    else $error("no wait cycle on ready low");
  a_ready_done: assert property (
    (in_cyc && wait_r == 2'h0 && rdy_s) |=> ##1 rsp_valid_o)
    else $error("cycle did not finish on ready");
  a_sel_float: assert property (
    (!off_n_s || power_down_i) |-> !ctl_oe_o)
    else $error("controls driven while inactive");
  a_bus_cycle_n_sel: assert property (
    pins_o.bus_cycle_n_n |-> (pins_o.ds_n && pins_o.ps_n && pins_o.is_n))
    else $error("select low without strobe");

endmodule : xmb_bus

// ==== test/xmb_mem_model.sv ====
// External memory and I/O device model for the bus master.
`timescale 1ns/1ps
module xmb_mem_model (
  // Clock and bus pins
  input  wire logic               ref_clk_i,
  input  wire xmb_pkg::xmb_pins_t pins_i,
  input  wire logic               ctl_oe_i,
  input  wire logic               de_i,
  input  wire logic [15:0]        dout_i,
  input  wire logic [3:0]         wait_i,
  // Device side
  output logic                    ready_o,
  output logic [15:0]             bus_o,
  output logic [15:0]             wr_q_o
);
  logic [7:0]  cnt  = 8'h00;
  logic [15:0] last = 16'h0000;
  logic        drv;
  // A released bus shows the inverse of its last value, not a held copy.
  assign drv = ctl_oe_i && pins_i.rw && !pins_i.bus_cycle_n_n &&
               !(pins_i.ds_n && pins_i.ps_n && pins_i.is_n);
  assign bus_o = de_i ? dout_i : (drv ? pins_i.addr ^ 16'h5A5A : ~last);
  assign ready_o = (cnt >= {4'h0, wait_i});
  always @(posedge ref_clk_i) begin
    last <= bus_o;
    cnt <= pins_i.bus_cycle_n_n ? 8'h00 : cnt + 8'h01;
    if (ctl_oe_i && !pins_i.we_n) wr_q_o <= bus_o;
  end
endmodule : xmb_mem_model

// ==== test/xmb_bus_tb.sv ====
// Self-checking testbench for the external bus master.
`timescale 1ns/1ps
module xmb_bus_tb;
  logic clk = 1'b0, rst = 1'b1, off_n = 1'b1, pd = 1'b0, vld = 1'b0;
  logic rdy, req_rdy, rsp_v, c_oe, a_oe, d_oe;
  logic [15:0] rdat, dout, bus, wq, rd;
  logic [3:0] wt = 4'h0;
  xmb_pkg::xmb_req_t req = '0;
  xmb_pkg::xmb_pins_t p;
  int error_cnt = 0, n_tests = 0, cyc, c0;
  xmb_bus dut (.ref_clk_i(clk), .rst_i(rst), .emu_off_n_i(off_n),
    .power_down_i(pd), .req_valid_i(vld), .req_i(req), .req_ready_o(req_rdy),
    .rsp_valid_o(rsp_v), .rsp_rdata_o(rdat), .ready_i(rdy), .pins_o(p),
    .ctl_oe_o(c_oe), .addr_oe_o(a_oe), .ext_data_i(bus),
    .ext_data_o(dout), .ext_data_oe_o(d_oe));
  xmb_mem_model mem (.ref_clk_i(clk), .pins_i(p), .ctl_oe_i(c_oe),
    .de_i(d_oe), .dout_i(dout), .wait_i(wt), .ready_o(rdy), .bus_o(bus),
    .wr_q_o(wq));
  initial forever #4 clk = ~clk;
  task test_done;
    $display("Mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // --------------------------------------------------------------------
  // One bus transfer, judging the pins in every strobe-low cycle
  // --------------------------------------------------------------------
  task xfer(input logic w, input xmb_pkg::xmb_space_t sp,
            input logic [15:0] a, input logic [15:0] d);
    int i;
    vld = 1'b1;
    req = '{write: w, space: sp, addr: a, wdata: d};
    for (i = 0; i < 50 && req_rdy !== 1'b1; i++) step(1);
    if (i == 50) begin
      error_cnt++;
      test_done();
    end
    step(1);
    vld = 1'b0;
    cyc = 0;
    for (i = 0; i < 200 && rsp_v !== 1'b1; i++) begin
      if (p.bus_cycle_n_n === 1'b0) begin
        cyc++;
        chk({p.ds_n, p.ps_n, p.is_n}, {~(3'b100 >> sp)});
        chk({p.addr, a_oe, c_oe}, {a, 2'b11});
        chk({p.rw, p.wr, p.we_n, d_oe}, {~w, w, ~w, w});
      end
      step(1);
    end
    if (i == 200) begin
      error_cnt++;
      test_done();
    end
    rd = rdat;
  endtask : xfer
  task t_write;
    for (int s = 0; s < 3; s++) begin
      xfer(1'b1, xmb_pkg::xmb_space_t'(s), 16'h1230 + 16'(s),
           16'hC3A0 + 16'(s));
      chk(wq, 16'hC3A0 + 16'(s));
      chk({p.bus_cycle_n_n, p.rw, p.wr, d_oe}, 4'hC);
    end
  endtask : t_write
  task t_wait;
    wt = 4'h0;
    xfer(1'b0, xmb_pkg::XMB_SP_DATA, 16'hBEEF, 16'h0000);
    chk(rd, 16'hBEEF ^ 16'h5A5A);
    c0 = cyc;
    wt = 4'h3;
    xfer(1'b0, xmb_pkg::XMB_SP_IO, 16'h0F0F, 16'h0000);
    chk(rd, 16'h0F0F ^ 16'h5A5A);
    chk(cyc >= c0 + 3, 1);
    wt = 4'h0;
  endtask : t_wait
  task t_off;
    off_n = 1'b0;
    step(4);
    chk({c_oe, a_oe, d_oe, req_rdy}, 4'h0);
    off_n = 1'b1;
    step(4);
  endtask : t_off
  task t_pd;
    xfer(1'b1, xmb_pkg::XMB_SP_PROG, 16'h7E81, 16'h0042);
    pd = 1'b1;
    step(4);
    chk({c_oe, d_oe, req_rdy, a_oe, p.addr}, {4'h1, 16'h7E81});
    pd = 1'b0;
    step(4);
  endtask : t_pd
  initial begin
    step(2);
    chk({c_oe, d_oe}, 2'b00);
    step(1);
    rst = 1'b0;
    step(4);
    chk({p.bus_cycle_n_n, p.rw, p.wr, p.ds_n, p.ps_n, p.is_n}, 6'h37);
    t_write();
    t_wait();
    t_off();
    t_pd();
    test_done();
  end
endmodule : xmb_bus_tb
